// ### bench/pjb_top_tb.sv
// self-checking bench of the justification binning block
`include "pjb_cfg.svh"
`default_nettype none

module pjb_top_tb import pjb_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;

    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pm_second_tick, h3_strobe, irq;
    logic next_group_head_bit;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] received_concat_bits, sw_path_ais_force, es_restart;
    pjb_just_t just;
    pjb_path_t path;
    int n_fail = 0;
    int check_count = 0;

    pjb_top pjb_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pm_second_tick(pm_second_tick),
        .just(just), .path(path), .h3_strobe(h3_strobe),
        .received_concat_bits(received_concat_bits), .next_group_head_bit(next_group_head_bit),
        .sw_path_ais_force(sw_path_ais_force), .es_restart(es_restart), .irq(irq));

    initial begin
        hclk = 1'h0;
        forever #20 hclk = ~hclk;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t pin %h expected %h", $time, got, exp);
        end
    endtask

    // sampling at the falling edge sees what the next rising edge samples
    task automatic bus(input logic wr, input logic [16:0] ix, input logic [31:0] wd);
        logic r;
        int n;
        n = 0;
        hsel <= 1'h1;
        haddr <= {13'h0000, ix, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do begin
            @(negedge hclk);
            r = hreadyout;
            @(posedge hclk);
            n++;
        end while (r !== 1'h1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(negedge hclk);
            r = hreadyout;
            rdv = hrdata;
            @(posedge hclk);
            n++;
        end while (r !== 1'h1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            $display("[ERR] %0t bus wait ran out", $time);
        end
    endtask

    task automatic wr(input logic [16:0] ix, input logic [31:0] d);
        bus(1'h1, ix, d);
    endtask

    task automatic rd_chk(input logic [16:0] ix, input logic [31:0] exp);
        bus(1'h0, ix, 32'h0);
        cmp(rdv, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic ev(input pjb_just_t v, input int n);
        repeat (n) begin
            just <= v;
            @(posedge hclk);
        end
        just <= '0;
        @(posedge hclk);
    endtask

    // tick held long enough to pass the two-flop synchroniser
    task automatic tick;
        pm_second_tick <= 1'h1;
        repeat (6) @(posedge hclk);
        pm_second_tick <= 1'h0;
        repeat (6) @(posedge hclk);
    endtask

    // restart pulses are one cycle wide, so they are gathered rather than sampled once
    task automatic watch(input int n, input logic [11:0] exp);
        logic [11:0] seen;
        seen = 12'h000;
        repeat (n) begin
            @(posedge hclk);
            h3_strobe <= 1'h0;
            path.overrun <= 12'h000;
            #1 seen = seen | es_restart;
        end
        cmp_pin(seen, exp);
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pm_second_tick = 1'h0;
        just = '0;
        path = '0;
        h3_strobe = 1'h0;
        received_concat_bits = 12'h000;
        next_group_head_bit = 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rd_chk(`PJB_IX_PROV, 32'h0);
        cmp_pin({11'h000, hresp}, 12'h000);
        wr(`PJB_IX_EXPMAP, 32'hFFFF0FB6);
        rd_chk(`PJB_IX_EXPMAP, 32'hFB6);
        wr(`PJB_IX_CMPMASK, 32'h0000FFFF);
        rd_chk(`PJB_IX_CMPMASK, 32'hFFF);
        received_concat_bits <= 12'hFB6;
        wr(`PJB_IX_RXMAP, 32'h0);
        rd_chk(`PJB_IX_RXMAP, 32'hFB6);
        rd_chk(17'h03006, 32'h0);
        wr(`PJB_IX_ALARM, 32'h7);
        rd_chk(`PJB_IX_ALARM, 32'h0);
        wr(`PJB_IX_EXPMAP, 32'hFB4);
        rd_chk(`PJB_IX_ALARM, 32'h1);
        cmp_pin({11'h000, irq}, 12'h000);
        wr(`PJB_IX_ALMASK, 32'h1);
        rd_chk(`PJB_IX_ALMASK, 32'h1);
        settle(2);
        cmp_pin({11'h000, irq}, 12'h001);
        wr(`PJB_IX_CMPMASK, 32'hFFD);
        wr(`PJB_IX_ALARM, 32'h1);
        rd_chk(`PJB_IX_ALARM, 32'h0);
        settle(2);
        cmp_pin({11'h000, irq}, 12'h000);
        wr(`PJB_IX_CMPMASK, 32'h0);
        received_concat_bits <= 12'h018;
        rd_chk(`PJB_IX_ALARM, 32'h2);
        // a chain into the next group is fine only from an aligned head
        received_concat_bits <= 12'hC00;
        next_group_head_bit <= 1'h1;
        wr(`PJB_IX_ALARM, 32'h7);
        rd_chk(`PJB_IX_ALARM, 32'h0);
        received_concat_bits <= 12'h000;
        rd_chk(`PJB_IX_ALARM, 32'h2);
        next_group_head_bit <= 1'h0;
        wr(`PJB_IX_ALARM, 32'h7);
        // counting on sts-1 #3, channel #1 activity must not leak in
        wr(`PJB_IX_PROV, 32'h3);
        ev('{12'h005, 12'h004, 12'h001, 12'h004}, 3);
        ev('{12'h004, 12'h001, 12'h004, 12'h000}, 2);
        tick();
        rd_chk(`PJB_IX_RXINC, 32'h5);
        rd_chk(`PJB_IX_RXDEC, 32'h3);
        rd_chk(`PJB_IX_GENINC, 32'h2);
        rd_chk(`PJB_IX_GENDEC, 32'h3);
        rd_chk(`PJB_IX_ALARM, 32'h4);
        tick();
        rd_chk(`PJB_IX_RXINC, 32'h0);
        ev('{12'h004, 12'h000, 12'h000, 12'h000}, 2005);
        tick();
        rd_chk(`PJB_IX_RXINC, 32'h7D0);
        ev('{12'h000, 12'h004, 12'h000, 12'h000}, 4);
        wr(`PJB_IX_PROV, 32'hD);
        ev('{12'h000, 12'h004, 12'h000, 12'h000}, 6);
        tick();
        rd_chk(`PJB_IX_RXDEC, 32'h4);
        // restart waits for h3 after a defect clears
        path.ais <= 12'h001;
        settle(3);
        path.ais <= 12'h000;
        watch(6, 12'h000);
        h3_strobe <= 1'h1;
        watch(3, 12'h001);
        path.lop <= 12'h800;
        settle(3);
        path.lop <= 12'h000;
        watch(4, 12'h000);
        h3_strobe <= 1'h1;
        watch(3, 12'h800);
        path.overrun <= 12'h020;
        watch(3, 12'h020);
        wr(`PJB_IX_SWAIS, 32'h3);
        cmp_pin(sw_path_ais_force, 12'h003);
        rd_chk(`PJB_IX_SWAIS, 32'h3);
        watch(20, 12'h000);
        fork
            wr(`PJB_IX_SWAIS, 32'h0);
            watch(6, 12'h003);
        join
        cmp_pin(sw_path_ais_force, 12'h000);
        complete_run();
    end

    initial begin
        #(40 * 20000);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
endmodule // pjb_top_tb

`default_nettype wire

// ### hdl/pjb_cfg.svh
// register map, field positions, reset values and limits of the justification binning block
`ifndef PJB_CFG_SVH
`define PJB_CFG_SVH

// register indices, byte address is four times the index
`define PJB_IX_PROV 17'h03000
`define PJB_IX_SWAIS 17'h03001
`define PJB_IX_RXINC 17'h03002
`define PJB_IX_RXDEC 17'h03003
`define PJB_IX_GENINC 17'h03004
`define PJB_IX_GENDEC 17'h03005
`define PJB_IX_EXPMAP 17'h04406
`define PJB_IX_CMPMASK 17'h0440B
`define PJB_IX_RXMAP 17'h0440F
`define PJB_IX_ALARM 17'h04413
`define PJB_IX_ALMASK 17'h04414

// monitor_channel_select field of the provisioning register
`define PJB_SEL_LSB 0
`define PJB_SEL_MSB 3
`define PJB_SEL_FIRST 4'h1
`define PJB_SEL_LAST 4'hC

// alarm and mask bit positions
`define PJB_AL_MISMATCH 0
`define PJB_AL_UNSUP 1
`define PJB_AL_PMDONE 2

// counter limit and reset values
`define PJB_SAT_MAX 11'h7D0
`define PJB_CNT_RST 11'h000
`define PJB_MAP_RST 12'h000
`define PJB_SEL_RST 4'h0
`define PJB_AL_RST 3'h0

`endif

// ### hdl/pjb_pkg.sv
// types of the justification binning block
`default_nettype none

package pjb_pkg;

    typedef enum logic [0:0] {
        PJB_BUS_IDLE = 1'b0,
        PJB_BUS_DATA = 1'b1
    } pjb_bus_t;

    // one-cycle justification events, one bit per sts-1
    typedef struct packed {
        logic [11:0] rx_inc;
        logic [11:0] rx_dec;
        logic [11:0] gen_inc;
        logic [11:0] gen_dec;
    } pjb_just_t;

    // per sts-1 defect levels and overrun pulses
    typedef struct packed {
        logic [11:0] ais;
        logic [11:0] lop;
        logic [11:0] overrun;
    } pjb_path_t;

    typedef struct packed {
        logic [2:0] tick_sync;
        pjb_bus_t bus;
        logic bus_write;
        logic [16:0] bus_ix;
        logic bus_ok;
        logic hready;
        logic [31:0] hrdata;
        logic [3:0] sel;
        logic [11:0] sw_ais;
        logic [3:0][10:0] cnt;
        logic [3:0][10:0] last;
        logic [11:0] exp_map;
        logic [11:0] cmp_mask;
        logic [2:0] status;
        logic [2:0] al_mask;
        logic irq;
        logic [11:0] def_prev;
        logic [11:0] pend;
        logic [11:0] force_prev;
        logic [11:0] restart;
    } pjb_state_t;

endpackage : pjb_pkg

`default_nettype wire

// ### hdl/pjb_top.sv
// justification binning, concatenation map check and elastic store restart for one sts-12
//
// Overview of operation
// - count four justification kinds on selected channel
// - tick rising edge copies counts to last-second
// - invalid select stops counting; tick still copies and clears counts
// - counters saturate at 2000, never wrap
// - restart store after ais, lop, overrun, force end
// - forced ais drives generator, no interpreter defect
// - ais or lop recovery takes effect at h3
// - writable expected map, one bit per sts-1
// - writable compare-enable mask per sts-1
// - read-only received map from interpreter
// - head is 0, members 1, lsb first
// - mismatch alarm on enabled differing channel
// - unsupported alarm for misaligned sts-3 crossing
//
// The AHB-Lite register port is this design's own decision.
`include "pjb_cfg.svh"
`default_nettype none

module pjb_top import pjb_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pm_second_tick,
    input wire pjb_just_t just,
    input wire pjb_path_t path,
    input wire logic h3_strobe,
    input wire logic [11:0] received_concat_bits,
    input wire logic next_group_head_bit,
    output logic [11:0] sw_path_ais_force,
    output logic [11:0] es_restart,
    output logic irq
);

    // ********************************
    // helpers
    // ********************************
    function automatic logic sel_valid(input logic [3:0] v);
        return (v >= `PJB_SEL_FIRST) && (v <= `PJB_SEL_LAST);
    endfunction

    // head 0, member 1; a member on an sts-3 boundary needs an aligned head
    function automatic logic unsup_scan(input logic [11:0] m, input logic nxt);
        logic aligned;
        logic bad;
        aligned = 1'b1;
        bad = 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (!m[i]) begin
                aligned = ((i % 3) == 0);
            end else if ((i % 3) == 0 && i != 0 && !aligned) begin
                bad = 1'b1;
            end
        end
        // a chain running into the next group still belongs to our head
        if (nxt && !aligned) begin
            bad = 1'b1;
        end
        return bad;
    endfunction

    function automatic logic [31:0] rd_word(input logic [16:0] ix, input pjb_state_t st,
                                           input logic [11:0] rxm);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (ix == `PJB_IX_PROV) begin
            w[`PJB_SEL_MSB:`PJB_SEL_LSB] = st.sel;
        end else if (ix == `PJB_IX_SWAIS) begin
            w[11:0] = st.sw_ais;
        end else if (ix == `PJB_IX_RXINC) begin
            w[10:0] = st.last[0];
        end else if (ix == `PJB_IX_RXDEC) begin
            w[10:0] = st.last[1];
        end else if (ix == `PJB_IX_GENINC) begin
            w[10:0] = st.last[2];
        end else if (ix == `PJB_IX_GENDEC) begin
            w[10:0] = st.last[3];
        end else if (ix == `PJB_IX_EXPMAP) begin
            w[11:0] = st.exp_map;
        end else if (ix == `PJB_IX_CMPMASK) begin
            w[11:0] = st.cmp_mask;
        end else if (ix == `PJB_IX_RXMAP) begin
            w[11:0] = rxm;
        end else if (ix == `PJB_IX_ALARM) begin
            w[2:0] = st.status;
        end else if (ix == `PJB_IX_ALMASK) begin
            w[2:0] = st.al_mask;
        end
        return w;
    endfunction

    pjb_state_t s;
    pjb_state_t n;
    logic tick;
    logic valid;
    logic [3:0] idx;
    logic [3:0][11:0] ev;
    logic [3:0] hit;
    logic mism;
    logic unsup;
    logic irq_cause;
    logic force_end;
    logic bus_wr;

    // ********************************
    // event selection
    // ********************************
    // first sync stage is only read by the second one
    assign tick = s.tick_sync[1] & ~s.tick_sync[2];
    assign valid = sel_valid(s.sel);
    assign idx = s.sel - `PJB_SEL_FIRST;
    assign ev[0] = just.rx_inc;
    assign ev[1] = just.rx_dec;
    assign ev[2] = just.gen_inc;
    assign ev[3] = just.gen_dec;
    assign mism = |(s.cmp_mask & (received_concat_bits ^ s.exp_map));
    assign unsup = unsup_scan(received_concat_bits, next_group_head_bit);
    assign irq_cause = |(s.status & s.al_mask);
    assign force_end = |(s.force_prev & ~s.sw_ais);
    assign bus_wr = (s.bus == PJB_BUS_DATA) && s.bus_write && s.bus_ok;

    generate
        for (genvar k = 0; k < 4; k++) begin : g_hit
            assign hit[k] = valid ? ev[k][idx] : 1'b0;
        end
    endgenerate

    // ********************************
    // next state
    // ********************************
    always_comb begin
        logic [2:0] clr;
        logic [2:0] set;
        logic dfx;
        n = s;
        clr = 3'h0;
        set = 3'h0;
        dfx = 1'b0;
        n.tick_sync = {s.tick_sync[1:0], pm_second_tick};

        for (int k = 0; k < 4; k++) begin
            if (tick) begin
                n.last[k] = s.cnt[k];
                // an event in the tick cycle opens the new second
                n.cnt[k] = hit[k] ? 11'h001 : `PJB_CNT_RST;
            end else if (hit[k] && s.cnt[k] < `PJB_SAT_MAX) begin
                n.cnt[k] = s.cnt[k] + 11'h001;
            end
        end

        // bus: one wait state so read data come from a flop after any write
        case (s.bus)
            PJB_BUS_IDLE: begin
                if (hsel && htrans[1] && hready) begin
                    n.bus = PJB_BUS_DATA;
                    n.bus_write = hwrite;
                    n.bus_ix = haddr[18:2];
                    n.bus_ok = (haddr[31:19] == 13'h0000) && (haddr[1:0] == 2'h0);
                    n.hready = 1'b0;
                end
            end
            PJB_BUS_DATA: begin
                n.bus = PJB_BUS_IDLE;
                n.hready = 1'b1;
                if (!s.bus_ok) begin
                    n.hrdata = 32'h0000_0000;
                end else if (!s.bus_write) begin
                    n.hrdata = rd_word(s.bus_ix, s, received_concat_bits);
                end else if (s.bus_ix == `PJB_IX_PROV) begin
                    n.sel = hwdata[`PJB_SEL_MSB:`PJB_SEL_LSB];
                end else if (s.bus_ix == `PJB_IX_SWAIS) begin
                    n.sw_ais = hwdata[11:0];
                end else if (s.bus_ix == `PJB_IX_EXPMAP) begin
                    n.exp_map = hwdata[11:0];
                end else if (s.bus_ix == `PJB_IX_CMPMASK) begin
                    n.cmp_mask = hwdata[11:0];
                end else if (s.bus_ix == `PJB_IX_ALARM) begin
                    clr = hwdata[2:0];
                end else if (s.bus_ix == `PJB_IX_ALMASK) begin
                    n.al_mask = hwdata[2:0];
                end
            end
            default: begin
                n.bus = PJB_BUS_IDLE;
                n.hready = 1'b1;
            end
        endcase

        // sticky alarms, a new event beats a same-cycle clear
        set[`PJB_AL_MISMATCH] = mism;
        set[`PJB_AL_UNSUP] = unsup;
        set[`PJB_AL_PMDONE] = tick;
        n.status = (s.status & ~clr) | set;
        n.irq = irq_cause;

        // store restarts; forcing never touches the interpreter defect inputs
        for (int i = 0; i < 12; i++) begin
            dfx = path.ais[i] | path.lop[i];
            n.def_prev[i] = dfx;
            n.restart[i] = (s.pend[i] & h3_strobe) | path.overrun[i]
                         | (s.force_prev[i] & ~s.sw_ais[i]);
            // recovery waits for the line h3 byte
            n.pend[i] = dfx ? 1'b0 : ((s.def_prev[i] & ~dfx) | (s.pend[i] & ~h3_strobe));
        end
        n.force_prev = s.sw_ais;
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s.tick_sync <= 3'h0;
            s.bus <= PJB_BUS_IDLE;
            s.bus_write <= 1'b0;
            s.bus_ix <= 17'h00000;
            s.bus_ok <= 1'b0;
            s.hready <= 1'b1;
            s.hrdata <= 32'h0000_0000;
            s.sel <= `PJB_SEL_RST;
            s.sw_ais <= `PJB_MAP_RST;
            s.cnt <= {4{`PJB_CNT_RST}};
            s.last <= {4{`PJB_CNT_RST}};
            s.exp_map <= `PJB_MAP_RST;
            s.cmp_mask <= `PJB_MAP_RST;
            s.status <= `PJB_AL_RST;
            s.al_mask <= `PJB_AL_RST;
            s.irq <= 1'b0;
            s.def_prev <= 12'h000;
            s.pend <= 12'h000;
            s.force_prev <= 12'h000;
            s.restart <= 12'h000;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = s.hready;
    assign hresp = 1'b0; // always okay
    assign hrdata = s.hrdata;
    assign sw_path_ais_force = s.sw_ais;
    assign es_restart = s.restart;
    assign irq = s.irq;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_force_end;
        s.sw_ais[0] ##1 !s.sw_ais[0];
    endsequence

    sequence s_accept;
        s.bus == PJB_BUS_IDLE && hsel && htrans[1] && hready;
    endsequence

    chk_cnt_saturate: assert property (
        s.cnt[0] <= `PJB_SAT_MAX && s.cnt[3] <= `PJB_SAT_MAX
    ) else $error("justification counter above limit");

    chk_tick_copy: assert property (
        tick |=> s.last[0] == $past(s.cnt[0]) && s.last[2] == $past(s.cnt[2])
    ) else $error("last-second copy wrong on tick");

    chk_tick_clear: assert property (
        tick |=> s.cnt[1] <= 11'h001 && s.cnt[3] <= 11'h001
    ) else $error("counter not cleared after tick");

    chk_invalid_hold: assert property (
        !valid && !tick |=> s.cnt == $past(s.cnt)
    ) else $error("counting while select invalid");

    chk_count_step: assert property (
        hit[0] && !tick && s.cnt[0] < `PJB_SAT_MAX |=> s.cnt[0] == $past(s.cnt[0]) + 11'h001
    ) else $error("selected increment not counted");

    chk_restart_h3: assert property (
        !h3_strobe && !(|path.overrun) && !force_end |=> s.restart == 12'h000
    ) else $error("restart outside h3 or cause");

    chk_force_restart: assert property (
        s_force_end |=> s.restart[0] && !s.force_prev[0]
    ) else $error("no restart at end of forced ais");

    chk_force_pulse: assert property (
        s_force_end |=> s.restart[0]
    ) else $error("forced ais end gave no restart");

    chk_mismatch_set: assert property (
        mism |=> s.status[`PJB_AL_MISMATCH]
    ) else $error("mismatch alarm not set");

    chk_unsup_set: assert property (
        unsup |=> s.status[`PJB_AL_UNSUP] ##1 irq == $past(irq_cause)
    ) else $error("unsupported alarm or irq wrong");

    chk_bus_wait: assert property (
        s_accept |=> !hreadyout ##1 hreadyout
    ) else $error("bus wait state wrong");

    sequence s_defect_clear;
        (path.ais[0] || path.lop[0]) ##1 !(path.ais[0] || path.lop[0]);
    endsequence

    chk_cnt_bound: assert property (
        s.cnt[1] <= `PJB_SAT_MAX && s.cnt[2] <= `PJB_SAT_MAX
    ) else $error("middle counter above limit");

    chk_sat_hold: assert property (
        hit[0] && !tick && s.cnt[0] == `PJB_SAT_MAX |=> s.cnt[0] == `PJB_SAT_MAX
    ) else $error("saturated counter moved");

    chk_tick_rest: assert property (
        tick |=> s.last[1] == $past(s.cnt[1]) && s.last[3] == $past(s.cnt[3])
    ) else $error("last-second decrement copy wrong");

    chk_last_hold: assert property (
        !tick |=> s.last == $past(s.last)
    ) else $error("last-second value changed without tick");

    chk_tick_zero: assert property (
        tick && !hit[0] |=> s.cnt[0] == `PJB_CNT_RST
    ) else $error("counter not zero after tick");

    chk_gen_step: assert property (
        hit[3] && !tick && s.cnt[3] < `PJB_SAT_MAX |=> s.cnt[3] == $past(s.cnt[3]) + 11'h001
    ) else $error("selected decrement not counted");

    chk_idle_hold: assert property (
        !hit[2] && !tick |=> s.cnt[2] == $past(s.cnt[2])
    ) else $error("counter moved without event");

    chk_pmdone_set: assert property (
        tick |=> s.status[`PJB_AL_PMDONE]
    ) else $error("transfer alarm not set");

    chk_mism_sticky: assert property (
        s.status[`PJB_AL_MISMATCH] && s.bus == PJB_BUS_IDLE |=> s.status[`PJB_AL_MISMATCH]
    ) else $error("mismatch alarm lost without clear");

    chk_irq_follow: assert property (
        irq_cause |=> irq
    ) else $error("unmasked alarm gave no irq");

    chk_overrun_restart: assert property (
        path.overrun[5] |=> es_restart[5]
    ) else $error("overrun gave no restart");

    chk_recover_pend: assert property (
        s_defect_clear |=> s.pend[0]
    ) else $error("defect recovery not pending");

    chk_recover_h3: assert property (
        s.pend[0] && h3_strobe |=> es_restart[0]
    ) else $error("no restart at h3 after recovery");

    chk_invalid_nohit: assert property (
        !valid |-> hit == 4'h0
    ) else $error("event taken with invalid select");

    chk_rxmap_read: assert property (
        s.bus == PJB_BUS_DATA && !s.bus_write && s.bus_ok && s.bus_ix == `PJB_IX_RXMAP
        |=> hrdata == {20'h00000, $past(received_concat_bits)}
    ) else $error("received map read wrong");

    chk_expmap_write: assert property (
        bus_wr && s.bus_ix == `PJB_IX_EXPMAP |=> s.exp_map == $past(hwdata[11:0])
    ) else $error("expected map write lost");

endmodule // pjb_top

`default_nettype wire
